// file: include/fts_pkg.sv
// shared constants for the flow-through no-wait burst memory
package fts_pkg;
	localparam int ADDR_W = 18;
	localparam int LANES = 4;
	localparam int LANE_W = 9;
	localparam int DATA_W = 32;
	localparam int WORD_W = 36;
	localparam int DEPTH = 262144;
	localparam int BURST_W = 2;
	localparam int PAR_POS = 8;
	localparam int BUF_DEPTH = 2;
	localparam logic [BURST_W-1:0] CNT_RESET = 2'h0;
	localparam logic [BURST_W-1:0] CNT_STEP = 2'h1;
	typedef enum logic [1:0] {FTS_IDLE, FTS_READ, FTS_WRITE} fts_op_e;
endpackage

// file: src/fts_sram.sv
// flow-through no-wait burst memory core with shared data pins
// Contract
// R1 - all synchronous inputs captured on rising edge
// R2 - hold high freezes state, ignores inputs
// R3 - advance high increments burst counter
// R4 - advance low loads new external address
// R5 - burst counter two bits, four words
// R6 - low address bits preset burst start
// R7 - order pin selects interleaved or linear
// R8 - write starts when read/write sampled low
// R9 - per-lane active-low write enables
// R10 - 256K words of 36 bits
// R11 - read and write back to back
// R12 - any inactive select means deselect
// R13 - shared data bus, parity per lane
// R14 - read data same cycle, gated by oe
// R15 - host sends write data next edge
`timescale 1ns/100ps
`default_nettype none
module fts_sram
	import fts_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clk_en_n,
	input wire logic advance_load,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic write_n,
	input wire logic [LANES-1:0] byte_lane_write_n,
	input wire logic chip_select_n,
	input wire logic chip_select_aux,
	input wire logic chip_select_aux_n,
	input wire logic burst_interleave,
	input wire logic out_enable_n,
	input wire logic [DATA_W-1:0] shared_data_lines_in,
	output logic [DATA_W-1:0] shared_data_lines_out,
	output logic [DATA_W-1:0] shared_data_lines_oe,
	input wire logic [LANES-1:0] lane_parity_bits_in,
	output logic [LANES-1:0] lane_parity_bits_out,
	output logic [LANES-1:0] lane_parity_bits_oe,
	output logic mon_in_ready,
	output logic mon_valid,
	output logic [WORD_W-1:0] mon_data,
	input wire logic mon_ready
);
	// next burst offset, linear adds and interleaved xors
	function automatic logic [BURST_W-1:0] burst_offset(input logic [BURST_W-1:0] start,
		input logic [BURST_W-1:0] cnt, input logic ilv);
		burst_offset = ilv ? (start ^ cnt) : BURST_W'(start + cnt); // see R7
	endfunction

	// packs pins into one stored word, parity at top of each lane
	function automatic logic [WORD_W-1:0] pack_word(input logic [DATA_W-1:0] d, input logic [LANES-1:0] p);
		pack_word = '0;
		for (int i = 0; i < LANES; i++) begin
			pack_word[i*LANE_W +: PAR_POS] = d[i*PAR_POS +: PAR_POS];
			pack_word[i*LANE_W + PAR_POS] = p[i];
		end
	endfunction

	logic [WORD_W-1:0] mem [DEPTH];
	fts_op_e op_q;
	logic [ADDR_W-1:BURST_W] base_q;
	logic [BURST_W-1:0] start_q;
	logic [BURST_W-1:0] cnt_q;
	logic [WORD_W-1:0] rd_word;
	logic [WORD_W-1:0] buf_mem [BUF_DEPTH];
	logic [1:0] buf_cnt;
	logic buf_wp;
	logic buf_rp;

	// decode of the pins sampled at this edge
	wire en = ~clk_en_n; // see R2
	wire sel = ~chip_select_n & chip_select_aux & ~chip_select_aux_n; // see R12
	wire [ADDR_W-1:0] cur_addr = {base_q, burst_offset(start_q, cnt_q, burst_interleave)};
	wire [WORD_W-1:0] wr_word = pack_word(shared_data_lines_in, lane_parity_bits_in);
	wire rd_cycle = (op_q == FTS_READ);
	wire wr_cycle = (op_q == FTS_WRITE);
	wire drive = rd_cycle & ~out_enable_n; // see R14
	wire push = en & rd_cycle & mon_in_ready;
	wire pop = mon_valid & mon_ready;
	fts_op_e next_op;
	assign next_op = !sel ? FTS_IDLE : (write_n ? FTS_READ : FTS_WRITE); // see R8

	// control registers; a load resets the counter, advance steps it
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			op_q <= FTS_IDLE;
			base_q <= '0;
			start_q <= CNT_RESET;
			cnt_q <= CNT_RESET;
		end else if (en) begin // see R1
			if (!advance_load) begin // see R4
				op_q <= next_op;
				base_q <= addr[ADDR_W-1:BURST_W];
				start_q <= addr[BURST_W-1:0]; // see R6
				cnt_q <= CNT_RESET;
			end else if (op_q != FTS_IDLE) begin
				cnt_q <= cnt_q + CNT_STEP; // see R3 see R5
			end
		end
	end

	// late write: data and lanes arrive the edge after the address
	always_ff @(posedge mclk) begin
		if (en && wr_cycle) begin // see R15 see R11
			for (int i = 0; i < LANES; i++) begin
				if (!byte_lane_write_n[i]) begin // see R9
					mem[cur_addr][i*LANE_W +: LANE_W] <= wr_word[i*LANE_W +: LANE_W];
				end
			end
		end
	end

	// flow-through read path, no output register on purpose
	assign rd_word = mem[cur_addr]; // see R10
	always_comb begin
		shared_data_lines_out = '0;
		lane_parity_bits_out = '0;
		for (int i = 0; i < LANES; i++) begin
			shared_data_lines_out[i*PAR_POS +: PAR_POS] = rd_word[i*LANE_W +: PAR_POS]; // see R13
			lane_parity_bits_out[i] = rd_word[i*LANE_W + PAR_POS];
		end
	end
	assign shared_data_lines_oe = {DATA_W{drive}};
	assign lane_parity_bits_oe = {LANES{drive}};

	// two-entry read monitor buffer; host cannot be stalled, so full drops
	assign mon_in_ready = (buf_cnt != 2'h2);
	// valid drops under hold so no word leaves while all state is frozen
	assign mon_valid = en & (buf_cnt != 2'h0); // see R2
	assign mon_data = buf_mem[buf_rp];
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			buf_cnt <= 2'h0;
			buf_wp <= 1'b0;
			buf_rp <= 1'b0;
		end else if (en) begin // see R2
			buf_wp <= buf_wp ^ push;
			buf_rp <= buf_rp ^ pop;
			buf_cnt <= 2'(buf_cnt + {1'b0, push} - {1'b0, pop});
		end
	end
	always_ff @(posedge mclk) begin
		if (push) begin
			buf_mem[buf_wp] <= rd_word;
		end
	end

	// helper capture of the last write, read by assertions only
	logic [ADDR_W-1:0] chk_addr;
	logic [LANE_W-1:0] chk_lane;
	logic chk_live;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			chk_addr <= '0;
			chk_lane <= '0;
			chk_live <= 1'b0;
		end else begin
			chk_live <= en & wr_cycle & ~byte_lane_write_n[0];
			chk_addr <= cur_addr;
			chk_lane <= wr_word[LANE_W-1:0];
		end
	end

	sequence s_load;
		en && !advance_load;
	endsequence
	sequence s_four_adv;
		(en && advance_load) [*4];
	endsequence

	property p_hold_freeze;
		@(posedge mclk) disable iff (!rst_n) clk_en_n |=> $stable(op_q) && $stable(cnt_q) && $stable(base_q)
			&& $stable(buf_cnt);
	endproperty
	a_hold_freeze: assert property (p_hold_freeze) else $error("state moved under hold"); // see R2

	property p_load_addr;
		@(posedge mclk) disable iff (!rst_n) s_load |=> cur_addr == $past(addr);
	endproperty
	a_load_addr: assert property (p_load_addr) else $error("loaded address wrong"); // see R4

	property p_wrap;
		@(posedge mclk) disable iff (!rst_n) (s_load and sel) ##1 s_four_adv |=> cur_addr == $past(cur_addr, 4);
	endproperty
	a_wrap: assert property (p_wrap) else $error("burst did not wrap after four"); // see R5

	property p_advance;
		@(posedge mclk) disable iff (!rst_n) en && advance_load && op_q != FTS_IDLE |=> cnt_q == 2'($past(cnt_q) + 1);
	endproperty
	a_advance: assert property (p_advance) else $error("counter did not step"); // see R3

	property p_order;
		@(posedge mclk) disable iff (!rst_n) s_load ##1 en && advance_load && op_q != FTS_IDLE
			|=> cur_addr[1:0] == (burst_interleave ? (start_q ^ 2'h1) : 2'(start_q + 2'h1));
	endproperty
	a_order: assert property (p_order) else $error("second burst word wrong"); // see R7

	property p_deselect;
		@(posedge mclk) disable iff (!rst_n) (s_load and !sel) |=> op_q == FTS_IDLE && shared_data_lines_oe == '0;
	endproperty
	a_deselect: assert property (p_deselect) else $error("deselect accessed array"); // see R12

	property p_read_drive;
		@(posedge mclk) disable iff (!rst_n) (s_load and (sel && write_n)) |=>
			(lane_parity_bits_oe == {LANES{~out_enable_n}}) && shared_data_lines_out[7:0] == rd_word[7:0];
	endproperty
	a_read_drive: assert property (p_read_drive) else $error("flow-through read not driven"); // see R14

	property p_write_lane;
		@(posedge mclk) disable iff (!rst_n) chk_live |-> mem[chk_addr][LANE_W-1:0] == chk_lane;
	endproperty
	a_write_lane: assert property (p_write_lane) else $error("enabled lane not written"); // see R9

	property p_mon_push;
		@(posedge mclk) disable iff (!rst_n) push |=> buf_cnt != 2'h0;
	endproperty
	a_mon_push: assert property (p_mon_push) else $error("read word lost from buffer"); // see R11

	// output enable high must keep both pin groups released
	property p_oe_gate;
		@(posedge mclk) disable iff (!rst_n) out_enable_n |-> shared_data_lines_oe == '0 && lane_parity_bits_oe == '0;
	endproperty
	a_oe_gate: assert property (p_oe_gate) else $error("pins driven with output enable off"); // see R14
endmodule // fts_sram
`default_nettype wire

// file: test/fts_host_model.sv
// host side of the shared data pins: write data driver and line resolution
`timescale 1ns/100ps
`default_nettype none
module fts_host_model
	import fts_pkg::*;
(
	input wire logic mclk,
	input wire logic drive,
	input wire logic [WORD_W-1:0] wd,
	input wire logic [WORD_W-1:0] mo,
	input wire logic [WORD_W-1:0] moe,
	output logic [WORD_W-1:0] bus
);
	logic [WORD_W-1:0] last;
	// undriven lines flip each cycle so a stale level never reads as good
	always_ff @(posedge mclk) last <= bus;
	// host drives only in the data cycle and lets go before reads
	assign bus = (moe & mo) | (~moe & (drive ? wd : ~last));
endmodule // fts_host_model
`default_nettype wire

// file: test/tb.sv
// self-checking bench for the flow-through burst memory
`timescale 1ns/100ps
`default_nettype none
module tb;
	import fts_pkg::*;
	typedef struct packed {logic [ADDR_W-1:0] a; logic [WORD_W-1:0] w; logic [LANES-1:0] ln;} fts_row_s;
	logic mclk = 0, rst_n = 0, clk_en_n = 0, advance_load = 0, write_n = 1, csn = 1, ilv = 0, oen = 0;
	logic mrdy = 0, drive = 0, cs_aux = 1, cs_aux_n = 0;
	logic [ADDR_W-1:0] addr = '0;
	logic [LANES-1:0] lanes_n = '1;
	logic [WORD_W-1:0] wd = '0;
	logic [WORD_W-1:0] mem [logic [ADDR_W-1:0]];
	wire logic [WORD_W-1:0] bus, mo, moe, mon_data;
	wire logic mon_in_ready, mon_valid;
	int failures = 0, n_checks = 0;
	// ordinary cases: address, word as {parity, data}, lane enables
	fts_row_s rows [6] = '{'{18'h00010, 36'hf_a1b2_c3d4, 4'h0}, '{18'h00010, 36'h0_5566_7788, 4'h5},
		'{18'h00011, 36'h3_0102_0304, 4'h0}, '{18'h00012, 36'hc_f0e1_d2c3, 4'h0},
		'{18'h00013, 36'h5_0a0b_0c0d, 4'h0}, '{18'h3ffff, 36'h9_ffff_0000, 4'h0}};
	fts_sram dut (.mclk(mclk), .rst_n(rst_n), .clk_en_n(clk_en_n), .advance_load(advance_load), .addr(addr),
		.write_n(write_n), .byte_lane_write_n(lanes_n), .chip_select_n(csn), .chip_select_aux(cs_aux),
		.chip_select_aux_n(cs_aux_n), .burst_interleave(ilv), .out_enable_n(oen),
		.shared_data_lines_in(bus[DATA_W-1:0]), .shared_data_lines_out(mo[DATA_W-1:0]),
		.shared_data_lines_oe(moe[DATA_W-1:0]), .lane_parity_bits_in(bus[WORD_W-1:DATA_W]),
		.lane_parity_bits_out(mo[WORD_W-1:DATA_W]), .lane_parity_bits_oe(moe[WORD_W-1:DATA_W]),
		.mon_in_ready(mon_in_ready), .mon_valid(mon_valid), .mon_data(mon_data), .mon_ready(mrdy));
	fts_host_model host (.mclk(mclk), .drive(drive), .wd(wd), .mo(mo), .moe(moe), .bus(bus));
	always #2.5 mclk = ~mclk;
	task automatic chk(input string nm, input logic [WORD_W-1:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// monitor words are lane ordered, parity on top of each byte
	function automatic logic [WORD_W-1:0] pk(input logic [WORD_W-1:0] w);
		for (int i = 0; i < LANES; i++) pk[9*i+:9] = {w[DATA_W+i], w[8*i+:8]};
	endfunction
	// load write, next edge data plus a read of the same word, no gap
	task automatic wr_rd(input fts_row_s r);
		@(posedge mclk);
		addr <= r.a;
		write_n <= 0;
		csn <= 0;
		@(posedge mclk);
		write_n <= 1;
		drive <= 1;
		wd <= r.w;
		lanes_n <= r.ln;
		@(posedge mclk);
		drive <= 0;
		lanes_n <= '1;
		for (int i = 0; i < LANES; i++) if (!r.ln[i]) begin
			mem[r.a][8*i+:8] = r.w[8*i+:8];
			mem[r.a][DATA_W+i] = r.w[DATA_W+i];
		end
		#1 chk("read back", bus, mem[r.a]);
	endtask
	initial begin
		repeat (3) @(posedge mclk);
		rst_n <= 1;
		#1 chk("reset oe", moe, '0);
		chk("reset monitor", {mon_valid, mon_in_ready}, 2'b01);
		foreach (rows[i]) wr_rd(rows[i]);
		$display("rows done");
		// bursts from start bits 01 in both orders, then one held edge
		for (int m = 0; m < 2; m++) begin
			@(posedge mclk);
			ilv <= m[0];
			addr <= 18'h00011;
			advance_load <= 0;
			clk_en_n <= 0;
			for (int k = 0; k < 5; k++) begin
				@(posedge mclk);
				advance_load <= 1;
				clk_en_n <= (k == 4);
				#1 chk("burst", bus, mem[{16'h0004, m ? 2'(1 ^ k) : 2'(1 + k)}]);
			end
			@(posedge mclk);
			#1 chk("hold", bus, mem[18'h00011]);
		end
		$display("bursts done");
		@(posedge mclk);
		clk_en_n <= 0;
		advance_load <= 0;
		csn <= 1;
		@(posedge mclk);
		#1 chk("deselect oe", moe, '0);
		@(posedge mclk);
		csn <= 0;
		oen <= 1;
		@(posedge mclk);
		#1 chk("oe off", moe, '0);
		// aux selects each deselect; the write tried under them must not land
		@(posedge mclk);
		oen <= 0;
		cs_aux <= 0;
		write_n <= 0;
		addr <= 18'h00010;
		@(posedge mclk);
		cs_aux <= 1;
		cs_aux_n <= 1;
		write_n <= 1;
		drive <= 1;
		wd <= '0;
		lanes_n <= '0;
		@(posedge mclk);
		cs_aux_n <= 0;
		drive <= 0;
		lanes_n <= '1;
		#1 chk("aux deselect oe", moe, '0);
		@(posedge mclk);
		#1 chk("no deselected write", bus, mem[18'h00010]);
		@(posedge mclk);
		csn <= 1;
		oen <= 0;
		@(posedge mclk);
		// receiver stalled all run: buffer full, oldest word first
		#1 chk("monitor full", {mon_in_ready, mon_valid}, 2'b01);
		chk("monitor word", mon_data, pk(rows[0].w));
		@(posedge mclk);
		mrdy <= 1;
		repeat (2) @(posedge mclk);
		#1 chk("monitor drained", {mon_in_ready, mon_valid}, 2'b10);
		// mid-run reset while a read drives the pins and a word is pushed
		@(posedge mclk);
		csn <= 0;
		mrdy <= 0;
		repeat (2) @(posedge mclk);
		rst_n <= 0;
		#1 chk("mid reset", {moe[0], mon_valid, mon_in_ready}, 3'b001);
		@(posedge mclk);
		rst_n <= 1;
		@(posedge mclk);
		#1 chk("read after reset", bus, mem[18'h00010]);
		$display("awkward cases done");
		report_and_stop;
	end
	// about 55 cycles expected; cut a hang well beyond that
	initial begin
		repeat (400) @(posedge mclk);
		failures++;
		report_and_stop;
	end
endmodule // tb
`default_nettype wire
